// ---- dlca_pkg.sv ----
// package: register map, field positions and types for the dac load, clear and alarm block
package dlca_pkg;
  localparam int unsigned NUM_DAC = 12;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned NUM_TEMP = 3;
  localparam int unsigned DW = 12;
  localparam int unsigned AW = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_DAC_DATA0 = 8'h00; // 12 words, 0x00..0x2c
  localparam logic [7:0] ADDR_CLR_CODE0 = 8'h40; // 12 words, 0x40..0x6c
  localparam logic [7:0] ADDR_CH_HI0 = 8'h80; // 4 words
  localparam logic [7:0] ADDR_CH_LO0 = 8'h90; // 4 words
  localparam logic [7:0] ADDR_T_HI0 = 8'ha0; // 3 words
  localparam logic [7:0] ADDR_T_LO0 = 8'hb0; // 3 words
  localparam logic [7:0] ADDR_CFG0 = 8'hc0;
  localparam logic [7:0] ADDR_SYNC_SEL = 8'hc4;
  localparam logic [7:0] ADDR_HW_CLR0 = 8'hc8;
  localparam logic [7:0] ADDR_HW_CLR1 = 8'hcc;
  localparam logic [7:0] ADDR_SW_CLR = 8'hd0;
  localparam logic [7:0] ADDR_AUTO_SRC = 8'hd4;
  localparam logic [7:0] ADDR_AUTO_EN = 8'hd8;
  localparam logic [7:0] ADDR_ALARM_CTL = 8'hdc;
  localparam logic [7:0] ADDR_STATUS = 8'he0;
  // field positions
  localparam int unsigned CFG0_LOAD_BIT = 0; // write 1: load trigger, reads 0
  localparam int unsigned CFG0_GLOBAL_ALARM_FLAG_BIT = 1; // read only global alarm
  localparam int unsigned ALARM_CTL_HOLD_OFF_BIT = 0;
  localparam int unsigned AUTO_SRC_OVERTEMP_BIT = 2;
  localparam int unsigned AUTO_EN_LSB = 3; // bits 14:3
  // status: [3:0] channel, [4] overtemp, [7:5] upper temp, [10:8] lower temp
  localparam int unsigned ST_CH_LSB = 0;
  localparam int unsigned ST_OT_BIT = 4;
  localparam int unsigned ST_UP_LSB = 5;
  localparam int unsigned ST_LO_LSB = 8;
  localparam int unsigned NUM_ST = 11;
  // threshold reset values: full open window
  localparam logic [11:0] HI_RST = 12'hfff;
  localparam logic [11:0] LO_RST = 12'h000;
  localparam logic [11:0] ZERO_CODE = 12'h000;
  localparam logic [11:0] OVERTEMP_LIMIT_DEFAULT = 12'h960; // 150 C at 1/16 C per lsb

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dlca_bus_s;

  typedef struct packed {
    logic [NUM_CH-1:0][11:0] ch;
    logic [NUM_TEMP-1:0][11:0] temp;
    logic [11:0] die;
  } dlca_meas_s;
endpackage : dlca_pkg

// ---- dlca_ctrl.sv ----
// dac load and clear control with alarm window monitor and status register
`timescale 1ns/1ps
module dlca_ctrl #(
  parameter logic [11:0] OVERTEMP_LIMIT = dlca_pkg::OVERTEMP_LIMIT_DEFAULT
) (
  input wire logic clk_sys, // 50 mhz system clock
  input wire logic arst_n, // async reset, active low
  input wire dlca_pkg::dlca_bus_s bus, // register write/read request
  output logic [31:0] rdata, // read data, cycle after read strobe
  input wire logic clear_pin_first_n, // first clear pin, active low, async
  input wire logic clear_pin_second_n, // second clear pin, active low, async
  input wire dlca_pkg::dlca_meas_s meas, // conversion results, same clock
  input wire logic meas_valid, // one-cycle pulse: monitoring cycle done
  input wire logic local_sensor_pd, // local temp sensor powered down
  output logic [dlca_pkg::NUM_DAC-1:0][11:0] dac_latch, // latch contents
  output logic alarm_out, // alarm pin level, low = alarm
  output logic alarm_oe // open-drain enable, high drives low
);
  localparam int unsigned ND = dlca_pkg::NUM_DAC;
  localparam int unsigned NS = dlca_pkg::NUM_ST;

  logic [ND-1:0][11:0] data_r;
  logic [ND-1:0][11:0] clr_code_r;
  logic [ND-1:0][11:0] latch_r;
  logic [dlca_pkg::NUM_CH-1:0][11:0] ch_hi_r;
  logic [dlca_pkg::NUM_CH-1:0][11:0] ch_lo_r;
  logic [dlca_pkg::NUM_TEMP-1:0][11:0] t_hi_r;
  logic [dlca_pkg::NUM_TEMP-1:0][11:0] t_lo_r;
  logic [ND-1:0] sync_sel_r;
  logic [ND-1:0] hw_mask0_r;
  logic [ND-1:0] hw_mask1_r;
  logic [ND-1:0] sw_clr_r;
  logic [ND-1:0] auto_en_r;
  logic [NS-1:0] auto_src_r;
  logic hold_off_r;
  logic load_pulse_r;
  logic [ND-1:0] pend_r;
  logic [ND-1:0] in_clr_r;
  logic [NS-1:0] status_r;
  logic [1:0] clr0_sync_r;
  logic [1:0] clr1_sync_r;
  logic [31:0] rdata_r;
  logic [NS-1:0] cond_r;
  logic [NS-1:0] cond_nxt;
  logic [ND-1:0] clr_nxt;
  logic [ND-1:0] data_wr;
  logic status_rd;
  logic global_alarm_flag;
  logic auto_act;
  logic [NS-1:0] src_view;

  // two-flop synchronisers for the asynchronous clear pins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clr0_sync_r <= 2'h3;
      clr1_sync_r <= 2'h3;
    end else begin
      clr0_sync_r <= {clr0_sync_r[0], clear_pin_first_n};
      clr1_sync_r <= {clr1_sync_r[0], clear_pin_second_n};
    end
  end

  // per-dac data write strobe decode
  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++) begin : g_wr
      assign data_wr[gi] = bus.wr && bus.addr == dlca_pkg::ADDR_DAC_DATA0 + 8'(4 * gi);
    end
  endgenerate
  assign status_rd = bus.rd && bus.addr == dlca_pkg::ADDR_STATUS;

  // configuration register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_r <= '0;
      clr_code_r <= '0;
      ch_hi_r <= {dlca_pkg::NUM_CH{dlca_pkg::HI_RST}};
      ch_lo_r <= {dlca_pkg::NUM_CH{dlca_pkg::LO_RST}};
      t_hi_r <= {dlca_pkg::NUM_TEMP{dlca_pkg::HI_RST}};
      t_lo_r <= {dlca_pkg::NUM_TEMP{dlca_pkg::LO_RST}};
      sync_sel_r <= '0;
      hw_mask0_r <= '0;
      hw_mask1_r <= '0;
      sw_clr_r <= '0;
      auto_en_r <= '0;
      auto_src_r <= '0;
      hold_off_r <= 1'b0;
    end else if (bus.wr) begin
      for (int i = 0; i < ND; i++) begin
        if (data_wr[i]) data_r[i] <= bus.wdata[11:0];
        if (bus.addr == dlca_pkg::ADDR_CLR_CODE0 + 8'(4 * i)) clr_code_r[i] <= bus.wdata[11:0];
      end
      for (int i = 0; i < dlca_pkg::NUM_CH; i++) begin
        if (bus.addr == dlca_pkg::ADDR_CH_HI0 + 8'(4 * i)) ch_hi_r[i] <= bus.wdata[11:0];
        if (bus.addr == dlca_pkg::ADDR_CH_LO0 + 8'(4 * i)) ch_lo_r[i] <= bus.wdata[11:0];
      end
      for (int i = 0; i < dlca_pkg::NUM_TEMP; i++) begin
        if (bus.addr == dlca_pkg::ADDR_T_HI0 + 8'(4 * i)) t_hi_r[i] <= bus.wdata[11:0];
        if (bus.addr == dlca_pkg::ADDR_T_LO0 + 8'(4 * i)) t_lo_r[i] <= bus.wdata[11:0];
      end
      unique case (bus.addr)
        dlca_pkg::ADDR_SYNC_SEL: sync_sel_r <= bus.wdata[ND-1:0];
        dlca_pkg::ADDR_HW_CLR0: hw_mask0_r <= bus.wdata[ND-1:0];
        dlca_pkg::ADDR_HW_CLR1: hw_mask1_r <= bus.wdata[ND-1:0];
        dlca_pkg::ADDR_SW_CLR: sw_clr_r <= bus.wdata[ND-1:0];
        dlca_pkg::ADDR_AUTO_SRC: auto_src_r <= bus.wdata[NS-1:0];
        dlca_pkg::ADDR_AUTO_EN: auto_en_r <= bus.wdata[dlca_pkg::AUTO_EN_LSB +: ND];
        dlca_pkg::ADDR_ALARM_CTL: hold_off_r <= bus.wdata[dlca_pkg::ALARM_CTL_HOLD_OFF_BIT];
        default: ;
      endcase
    end
  end

  // load trigger: one cycle pulse, never stored as a readable bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) load_pulse_r <= 1'b0;
    else load_pulse_r <= bus.wr && bus.addr == dlca_pkg::ADDR_CFG0
                         && bus.wdata[dlca_pkg::CFG0_LOAD_BIT];
  end

  // alarm condition evaluation, combinational on the current measurements
  always_comb begin
    cond_nxt = '0;
    for (int i = 0; i < dlca_pkg::NUM_CH; i++) begin
      // an inverted window trips one side always, so the bit stays set
      cond_nxt[dlca_pkg::ST_CH_LSB + i] = meas.ch[i] > ch_hi_r[i] || meas.ch[i] < ch_lo_r[i];
    end
    cond_nxt[dlca_pkg::ST_OT_BIT] = !local_sensor_pd && meas.die > OVERTEMP_LIMIT;
    for (int i = 0; i < dlca_pkg::NUM_TEMP; i++) begin
      cond_nxt[dlca_pkg::ST_UP_LSB + i] = meas.temp[i] > t_hi_r[i];
      cond_nxt[dlca_pkg::ST_LO_LSB + i] = meas.temp[i] < t_lo_r[i];
    end
  end

  // condition register, refreshed once per monitoring cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) cond_r <= '0;
    else if (meas_valid) cond_r <= cond_nxt;
  end

  // status bits: new event wins over a clearing status read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
    end else if (hold_off_r) begin
      if (meas_valid) status_r <= cond_nxt;
    end else begin
      status_r <= (status_rd ? '0 : status_r) | (meas_valid ? cond_nxt : '0);
    end
  end

  assign global_alarm_flag = |status_r;
  assign alarm_oe = global_alarm_flag;
  assign alarm_out = !global_alarm_flag;

  // auto-clear sources seen through the status bits; overtemp is source bit 2 but
  // status bit 4, so those two places swap, and it is muted while the sensor is down
  always_comb begin
    src_view = status_r;
    src_view[dlca_pkg::AUTO_SRC_OVERTEMP_BIT] = status_r[dlca_pkg::ST_OT_BIT]
                                                && !local_sensor_pd;
    src_view[dlca_pkg::ST_OT_BIT] = status_r[dlca_pkg::AUTO_SRC_OVERTEMP_BIT];
  end
  assign auto_act = |(auto_src_r & src_view);
  assign clr_nxt = (clr0_sync_r[1] ? '0 : hw_mask0_r)
                 | (clr1_sync_r[1] ? '0 : hw_mask1_r)
                 | sw_clr_r
                 | (auto_act ? auto_en_r : '0);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) in_clr_r <= '0;
    else in_clr_r <= clr_nxt;
  end

  // latch update: clear has priority, then clear exit, then normal loads
  generate
    for (gi = 0; gi < ND; gi++) begin : g_latch
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          latch_r[gi] <= '0;
          pend_r[gi] <= 1'b0;
        end else begin
          if (clr_nxt[gi]) latch_r[gi] <= clr_code_r[gi];
          else if (in_clr_r[gi]) latch_r[gi] <= data_r[gi];
          else if (!sync_sel_r[gi] && data_wr[gi]) latch_r[gi] <= bus.wdata[11:0];
          else if (sync_sel_r[gi] && load_pulse_r && pend_r[gi])
            latch_r[gi] <= data_r[gi];
          // a data write in the trigger cycle stays pending for the next trigger
          if (sync_sel_r[gi] && data_wr[gi]) pend_r[gi] <= 1'b1;
          else if (load_pulse_r) pend_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign dac_latch = latch_r;

  // read mux, data appear the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      if (bus.rd) begin
        for (int i = 0; i < ND; i++) begin
          if (bus.addr == dlca_pkg::ADDR_DAC_DATA0 + 8'(4 * i)) rdata_r <= {20'h0, latch_r[i]};
          if (bus.addr == dlca_pkg::ADDR_CLR_CODE0 + 8'(4 * i)) rdata_r <= {20'h0, clr_code_r[i]};
        end
        for (int i = 0; i < dlca_pkg::NUM_CH; i++) begin
          if (bus.addr == dlca_pkg::ADDR_CH_HI0 + 8'(4 * i)) rdata_r <= {20'h0, ch_hi_r[i]};
          if (bus.addr == dlca_pkg::ADDR_CH_LO0 + 8'(4 * i)) rdata_r <= {20'h0, ch_lo_r[i]};
        end
        for (int i = 0; i < dlca_pkg::NUM_TEMP; i++) begin
          if (bus.addr == dlca_pkg::ADDR_T_HI0 + 8'(4 * i)) rdata_r <= {20'h0, t_hi_r[i]};
          if (bus.addr == dlca_pkg::ADDR_T_LO0 + 8'(4 * i)) rdata_r <= {20'h0, t_lo_r[i]};
        end
        unique case (bus.addr)
          dlca_pkg::ADDR_CFG0: rdata_r <= {30'h0, global_alarm_flag, 1'b0};
          dlca_pkg::ADDR_SYNC_SEL: rdata_r <= {20'h0, sync_sel_r};
          dlca_pkg::ADDR_HW_CLR0: rdata_r <= {20'h0, hw_mask0_r};
          dlca_pkg::ADDR_HW_CLR1: rdata_r <= {20'h0, hw_mask1_r};
          dlca_pkg::ADDR_SW_CLR: rdata_r <= {20'h0, sw_clr_r};
          dlca_pkg::ADDR_AUTO_SRC: rdata_r <= {21'h0, auto_src_r};
          dlca_pkg::ADDR_AUTO_EN: rdata_r <= {17'h0, auto_en_r, 3'h0};
          dlca_pkg::ADDR_ALARM_CTL: rdata_r <= {31'h0, hold_off_r};
          dlca_pkg::ADDR_STATUS: rdata_r <= {21'h0, status_r};
          default: ;
        endcase
      end
    end
  end
  assign rdata = rdata_r;

  // checks
  sequence s_trig;
    load_pulse_r && !clr_nxt[0] && !in_clr_r[0] && sync_sel_r[0] && pend_r[0];
  endsequence

  a_async_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    data_wr[0] && !sync_sel_r[0] && !clr_nxt[0] && !in_clr_r[0]
    |=> latch_r[0] == $past(bus.wdata[11:0]))
    else $error("async dac write did not reach latch");
  a_sync_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    data_wr[0] && sync_sel_r[0] && !load_pulse_r && !clr_nxt[0] && !in_clr_r[0]
    |=> $stable(latch_r[0]))
    else $error("sync dac write changed latch");
  a_trig_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_trig |=> latch_r[0] == $past(data_r[0]))
    else $error("trigger did not load pending latch");
  a_trig_skip: assert property (@(posedge clk_sys) disable iff (!arst_n)
    load_pulse_r && !pend_r[1] && !clr_nxt[1] && !in_clr_r[1] && !data_wr[1] |=> $stable(latch_r[1]))
    else $error("untouched dac reloaded");
  a_clear_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clr_nxt[0] |=> latch_r[0] == $past(clr_code_r[0]))
    else $error("clear code not loaded");
  a_clear_exit: assert property (@(posedge clk_sys) disable iff (!arst_n)
    in_clr_r[0] && !clr_nxt[0] |=> latch_r[0] == $past(data_r[0]))
    else $error("clear exit did not restore data");
  a_pin_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !clr0_sync_r[1] && hw_mask0_r[0] |=> in_clr_r[0])
    else $error("first clear pin ignored");
  a_pin2_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !clr1_sync_r[1] && hw_mask1_r[0] |=> in_clr_r[0])
    else $error("second clear pin ignored");
  a_sw_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bus.wr && bus.addr == dlca_pkg::ADDR_SW_CLR && bus.wdata[0] |=> ##1 in_clr_r[0])
    else $error("software clear ignored");
  a_overtemp_pd: assert property (@(posedge clk_sys) disable iff (!arst_n)
    local_sensor_pd && meas_valid && !status_r[dlca_pkg::ST_OT_BIT]
    |=> !status_r[dlca_pkg::ST_OT_BIT])
    else $error("overtemp active while sensor down");
  a_global_alarm_flag_pin: assert property (@(posedge clk_sys) disable iff (!arst_n)
    alarm_oe == (status_r != '0) && alarm_out == !alarm_oe)
    else $error("alarm pin does not follow status");
  a_latched_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !hold_off_r && status_r[0] && !status_rd |=> status_r[0])
    else $error("latched alarm dropped without read");
  a_trig_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n)
    load_pulse_r && !(bus.wr && bus.addr == dlca_pkg::ADDR_CFG0) |=> !load_pulse_r)
    else $error("load pulse longer than one cycle");

  sequence s_ot_event;
    status_r[dlca_pkg::ST_OT_BIT] && auto_src_r[dlca_pkg::AUTO_SRC_OVERTEMP_BIT]
      && !local_sensor_pd && auto_en_r[0];
  endsequence

  a_auto_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_ot_event |=> in_clr_r[0])
    else $error("overtemp auto clear ignored");
  a_overtemp_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid && !local_sensor_pd && meas.die > OVERTEMP_LIMIT |=> status_r[dlca_pkg::ST_OT_BIT])
    else $error("overtemp flag not set");
  a_alarm_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid |=> (status_r & $past(cond_nxt)) == $past(cond_nxt))
    else $error("out of range source not flagged");
  a_global_alarm_flag_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bus.rd && bus.addr == dlca_pkg::ADDR_CFG0
    |=> rdata[dlca_pkg::CFG0_GLOBAL_ALARM_FLAG_BIT] == $past(global_alarm_flag))
    else $error("global flag read wrong");
  a_read_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !hold_off_r && status_rd && !meas_valid |=> status_r == '0)
    else $error("status read did not clear");
  a_hold_follow: assert property (@(posedge clk_sys) disable iff (!arst_n)
    hold_off_r && meas_valid |=> status_r == $past(cond_nxt))
    else $error("hold-off status does not follow condition");
  a_window_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid && (meas.ch[0] > ch_hi_r[0] || meas.ch[0] < ch_lo_r[0]) |=> status_r[0])
    else $error("channel window alarm missed");
  a_inverted_win: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid && ch_hi_r[3] < ch_lo_r[3] |=> status_r[3])
    else $error("inverted window alarm missed");
  a_temp_upper: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid && meas.temp[0] > t_hi_r[0] |=> status_r[dlca_pkg::ST_UP_LSB])
    else $error("upper temperature flag missed");
  a_temp_lower: assert property (@(posedge clk_sys) disable iff (!arst_n)
    meas_valid && meas.temp[2] < t_lo_r[2] |=> status_r[dlca_pkg::ST_LO_LSB + 2])
    else $error("lower temperature flag missed");
  a_sync_pend: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sync_sel_r[1] && data_wr[1] |=> pend_r[1])
    else $error("sync write not marked pending");
  a_trig_all: assert property (@(posedge clk_sys) disable iff (!arst_n)
    load_pulse_r && sync_sel_r[1] && pend_r[1] && !clr_nxt[1] && !in_clr_r[1]
    |=> latch_r[1] == $past(data_r[1]))
    else $error("trigger missed second dac");
  a_clear_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
    clr_nxt[0] && !data_wr[0] |=> $stable(data_r[0]))
    else $error("clear changed data register");
endmodule : dlca_ctrl

// ---- dlca_host.sv ----
// host model: drives the register strobes and takes read data
`timescale 1ns/1ps
module dlca_host (
  input wire logic clk_sys, // system clock
  output dlca_pkg::dlca_bus_s bus, // register request
  input wire logic [31:0] rdata // read data, cycle after strobe
);
  initial begin
    bus = '0;
  end

  // one-cycle write; address and data are inverted once released so stale values never match
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    bus.addr <= ~a;
    bus.wdata <= ~d;
  endtask : wr

  // one-cycle read; data taken in the single cycle it stands
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    bus.addr <= ~a;
    #1;
    d = rdata;
  endtask : rd
endmodule : dlca_host

// ---- dlca_ctrl_tb.sv ----
// self-checking bench for the dac load, clear and alarm block
`timescale 1ns/1ps
module dlca_ctrl_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic cp0_n = 1'b1;
  logic cp1_n = 1'b1;
  logic mv = 1'b0;
  logic pd = 1'b0;
  dlca_pkg::dlca_bus_s bus;
  dlca_pkg::dlca_meas_s m;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [dlca_pkg::NUM_DAC-1:0][11:0] dac_latch;
  logic alarm_out;
  logic alarm_oe;
  int failures = 0;
  int total_checks = 0;
  int data_m[12];
  int latch_m[12];
  int code_m[12];
  logic [11:0] msk;
  logic [11:0] sync;

  dlca_host host (.clk_sys(clk_sys), .bus(bus), .rdata(rdata));
  dlca_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .clear_pin_first_n(cp0_n), .clear_pin_second_n(cp1_n), .meas(m), .meas_valid(mv),
    .local_sensor_pd(pd), .dac_latch(dac_latch), .alarm_out(alarm_out), .alarm_oe(alarm_oe));

  // 50 mhz clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // cleared dacs show their clear code, the rest the modelled latch
  task automatic chk_lat(input logic [11:0] clr);
    for (int i = 0; i < 12; i++) begin
      chk(32'(dac_latch[i]), clr[i] ? 32'(code_m[i]) : 32'(latch_m[i]), "latch");
    end
  endtask : chk_lat

  // margin covers the longest latency, the three-edge clear pin path
  task automatic settle;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic pulse;
    @(posedge clk_sys);
    mv <= 1'b1;
    @(posedge clk_sys);
    mv <= 1'b0;
    settle();
  endtask : pulse

  task automatic st(input logic [31:0] exp);
    host.rd(dlca_pkg::ADDR_STATUS, v);
    chk(v, exp, "status");
  endtask : st

  // all readings inside the reset window
  task automatic idle;
    m.ch <= {4{12'h800}};
    m.temp <= {3{12'h100}};
    m.die <= 12'h000;
  endtask : idle

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    finish_test();
  end

  initial begin
    m = '0;
    idle();
    void'($urandom(32'h5a6e));
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle();
    chk_lat(12'h000);
    chk({30'b0, alarm_oe, alarm_out}, 32'h1, "pin idle");
    // asynchronous mode: each latch follows its write one cycle later
    for (int i = 0; i < 12; i++) begin
      data_m[i] = $urandom & 12'hfff;
      latch_m[i] = data_m[i];
      code_m[i] = $urandom & 12'hfff;
      host.wr(dlca_pkg::ADDR_DAC_DATA0 + 8'(4 * i), 32'(data_m[i]));
      #1;
      chk(32'(dac_latch[i]), 32'(data_m[i]), "async load");
      host.wr(dlca_pkg::ADDR_CLR_CODE0 + 8'(4 * i), 32'(code_m[i]));
    end
    // random sync set: synchronous dacs wait for the trigger
    sync = $urandom & 12'hfff;
    host.wr(dlca_pkg::ADDR_SYNC_SEL, 32'(sync));
    for (int i = 0; i < 12; i++) begin
      data_m[i] = $urandom & 12'hfff;
      if (!sync[i]) latch_m[i] = data_m[i];
      host.wr(dlca_pkg::ADDR_DAC_DATA0 + 8'(4 * i), 32'(data_m[i]));
    end
    settle();
    chk_lat(12'h000);
    host.wr(dlca_pkg::ADDR_CFG0, 32'h1);
    for (int i = 0; i < 12; i++) latch_m[i] = data_m[i];
    settle();
    chk_lat(12'h000);
    host.rd(dlca_pkg::ADDR_CFG0, v);
    chk(v, 32'h0, "trigger bit");
    // unmapped place: write ignored, read zero
    host.wr(8'hf0, 32'hffffffff);
    host.rd(8'hf0, v);
    chk(v, 32'h0, "unmapped");
    // each pin has its own mask; dac0 is written while it is cleared
    for (int p = 0; p < 2; p++) begin
      msk = ($urandom & 12'hfff) | 12'h001;
      host.wr(p ? dlca_pkg::ADDR_HW_CLR1 : dlca_pkg::ADDR_HW_CLR0, 32'(msk));
      @(posedge clk_sys);
      cp0_n <= (p != 0);
      cp1_n <= (p == 0);
      settle();
      data_m[0] = $urandom & 12'hfff;
      latch_m[0] = data_m[0];
      host.wr(dlca_pkg::ADDR_DAC_DATA0, 32'(data_m[0]));
      settle();
      chk_lat(msk);
      @(posedge clk_sys);
      cp0_n <= 1'b1;
      cp1_n <= 1'b1;
      settle();
      chk_lat(12'h000);
    end
    msk = $urandom & 12'hfff;
    host.wr(dlca_pkg::ADDR_SW_CLR, 32'(msk));
    settle();
    chk_lat(msk);
    host.wr(dlca_pkg::ADDR_SW_CLR, 32'h0);
    settle();
    chk_lat(12'h000);
    // latched channel alarm, upper bound only programmed
    host.wr(dlca_pkg::ADDR_CH_HI0 + 8'h04, 32'h900);
    m.ch[1] <= 12'ha00;
    pulse();
    chk({30'b0, alarm_oe, alarm_out}, 32'h2, "pin active");
    host.rd(dlca_pkg::ADDR_CFG0, v);
    chk(v, 32'h2, "global flag");
    m.ch[1] <= 12'h800;
    pulse();
    st(32'h2);
    st(32'h0);
    chk({30'b0, alarm_oe, alarm_out}, 32'h1, "pin released");
    host.wr(dlca_pkg::ADDR_T_HI0, 32'h200);
    host.wr(dlca_pkg::ADDR_T_LO0 + 8'h08, 32'h050);
    m.temp[0] <= 12'h300;
    m.temp[2] <= 12'h010;
    pulse();
    st(32'h420);
    // inverted window flags the channel whatever the reading
    idle();
    host.wr(dlca_pkg::ADDR_CH_HI0 + 8'h0c, 32'h100);
    host.wr(dlca_pkg::ADDR_CH_LO0 + 8'h0c, 32'h200);
    m.ch[3] <= 12'h180;
    pulse();
    st(32'h8);
    host.wr(dlca_pkg::ADDR_CH_HI0 + 8'h0c, 32'hfff);
    host.wr(dlca_pkg::ADDR_CH_LO0 + 8'h0c, 32'h000);
    idle();
    pulse();
    st(32'h0);
    // hold-off mode: flag follows the condition with no read
    host.wr(dlca_pkg::ADDR_ALARM_CTL, 32'h1);
    host.wr(dlca_pkg::ADDR_CH_LO0, 32'h100);
    m.ch[0] <= 12'h000;
    pulse();
    chk({30'b0, alarm_oe, alarm_out}, 32'h2, "follow set");
    m.ch[0] <= 12'h800;
    pulse();
    chk({30'b0, alarm_oe, alarm_out}, 32'h1, "follow clear");
    host.wr(dlca_pkg::ADDR_ALARM_CTL, 32'h0);
    // overtemperature drives auto clear of the enabled dacs
    msk = $urandom & 12'hfff;
    host.wr(dlca_pkg::ADDR_AUTO_EN, 32'(msk) << 3);
    host.wr(dlca_pkg::ADDR_AUTO_SRC, 32'h4);
    m.die <= 12'hfff;
    pulse();
    chk_lat(msk);
    st(32'h10);
    m.die <= 12'h000;
    pulse();
    st(32'h0);
    settle();
    chk_lat(12'h000);
    pd <= 1'b1;
    m.die <= 12'hfff;
    pulse();
    chk_lat(12'h000);
    st(32'h0);
    finish_test();
  end
endmodule : dlca_ctrl_tb
